/* File: hdl/perf_monitor_counters.sv */
// Purpose: T1/J1 performance-monitor counter bank with indirect access
// Assumes: Event pulses come from framer logic on CLK_SYS_I, one cycle each
// Notes:   Counters saturate at full scale; overflow raises a sticky flag
//
// What this block does
// - Each counter overflow sets its own flag
// - Flag interrupts only when its enable set
// - Counters reached only through select/data window
// - Auto mode copies selected counter every second
// - Manual bit rising edge copies selected counter
// - Every copy clears all counters together
// - Event during copy cycle is never lost
// - Framing format steers events to counters
// - Line code counter: AMI or B8ZS violations
// - Framing counter: F-bit or alignment-bit errors
// - CRC-6 counter counts only in ESF
// - Alignment change counter counts position changes
// - Out-of-frame counter counts sync losses
// - Pattern checker counter counts pattern bit errors
`timescale 1ns/10ps
module perf_monitor_counters #(
  parameter int unsigned SECOND_CYCLES = perf_monitor_pkg::ONE_SECOND_CYCLES
) (
  // Clock and reset
  input  wire logic                                  CLK_SYS_I,
  input  wire logic                                  RST_I,
  // Avalon-MM slave
  input  wire logic [perf_monitor_pkg::ADDR_W-1:0]   AVS_ADDRESS_I,
  input  wire logic                                  AVS_READ_I,
  input  wire logic                                  AVS_WRITE_I,
  input  wire logic [perf_monitor_pkg::BUS_W-1:0]    AVS_WRITEDATA_I,
  input  wire logic [perf_monitor_pkg::BE_W-1:0]     AVS_BYTEENABLE_I,
  output logic      [perf_monitor_pkg::BUS_W-1:0]    AVS_READDATA_O,
  output logic                                       AVS_WAITREQUEST_O,
  // Receive path events
  input  wire logic                                  BPV_EVENT_I,
  input  wire logic                                  B8ZS_CV_EVENT_I,
  input  wire logic                                  FBIT_ERR_EVENT_I,
  input  wire logic                                  FAS_ERR_EVENT_I,
  input  wire logic                                  CRC6_ERR_EVENT_I,
  input  wire logic                                  DDS_ERR_EVENT_I,
  input  wire logic                                  ALIGN_CHANGE_EVENT_I,
  input  wire logic                                  FRAME_LOSS_EVENT_I,
  input  wire logic                                  PATTERN_ERR_EVENT_I,
  // Interrupt
  output logic                                       IRQ_O
);
  import perf_monitor_pkg::*;

  logic [SEL_W-1:0]      select_reg;
  logic [DATA_W-1:0]     window_reg;
  logic                  trigger_reg;
  logic                  trigger_prev_reg;
  logic [CFG_W-1:0]      cfg_reg;
  logic [NUM_CNT-1:0]    enable_reg;
  logic [NUM_CNT-1:0]    enable_next;
  logic [NUM_CNT-1:0]    flags_reg;
  logic [NUM_CNT-1:0]    flags_next;
  logic [NUM_CNT-1:0]    flags_clr;
  logic [CNT_W-1:0]      cnt_reg [NUM_CNT];
  logic [NUM_CNT-1:0]    inc;
  logic [NUM_CNT-1:0]    ovf;
  logic [TICK_W-1:0]     tick_reg;
  logic                  tick_end;
  logic                  manual_rise;
  logic                  snap;
  logic                  waitreq_reg;
  logic [BUS_W-1:0]      readdata_reg;
  logic                  irq_reg;
  logic                  req;
  logic                  accept;
  logic [IDX_W-1:0]      idx;
  logic [DATA_W-1:0]     rd_byte;
  logic                  wr_en;
  frame_format_type      fmt;
  logic                  b8zs_mode;
  logic                  j1_mode;
  logic                  auto_en;

  // Byte of the selected indirect counter
  function automatic logic [DATA_W-1:0] pick_byte(
    input logic [SEL_W-1:0] sel,
    input logic [CNT_W-1:0] c [NUM_CNT]
  );
    logic [DATA_W-1:0] b;
    b = BYTE_RST;
    case (sel)
      SEL_CRC_LO:  b = c[CNT_CRC][DATA_W-1:0];
      SEL_CRC_HI:  b = c[CNT_CRC][CNT_W-1:DATA_W];
      SEL_FER_LO:  b = c[CNT_FER][DATA_W-1:0];
      SEL_FER_HI:  b = c[CNT_FER][CNT_W-1:DATA_W];
      SEL_COFA:    b = c[CNT_COFA][DATA_W-1:0];
      SEL_OOF:     b = c[CNT_OOF][DATA_W-1:0];
      SEL_PRGD_LO: b = c[CNT_PRGD][DATA_W-1:0];
      SEL_PRGD_HI: b = c[CNT_PRGD][CNT_W-1:DATA_W];
      SEL_LCV_LO:  b = c[CNT_LCV][DATA_W-1:0];
      SEL_LCV_HI:  b = c[CNT_LCV][CNT_W-1:DATA_W];
      SEL_DDS_LO:  b = c[CNT_DDS][DATA_W-1:0];
      SEL_DDS_HI:  b = c[CNT_DDS][CNT_W-1:DATA_W];
      default:     b = BYTE_RST;
    endcase
    return b;
  endfunction

  assign fmt       = frame_format_type'(cfg_reg[CFG_FMT_LSB +: 2]);
  assign b8zs_mode = cfg_reg[CFG_B8ZS_BIT];
  assign j1_mode   = cfg_reg[CFG_J1_BIT];
  assign auto_en   = cfg_reg[CFG_AUTO_BIT];

  // Bus handshake: one wait state, then answer
  assign req    = AVS_READ_I | AVS_WRITE_I;
  assign accept = req & ~waitreq_reg;
  assign idx    = AVS_ADDRESS_I[IDX_LSB +: IDX_W];
  assign wr_en  = accept & AVS_WRITE_I & AVS_BYTEENABLE_I[0];

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      waitreq_reg <= 1'b1;
    end else begin
      waitreq_reg <= ~(req & waitreq_reg);
    end
  end

  always_comb begin
    rd_byte = BYTE_RST;
    if (idx == IDX_SELECT_PORT) begin
      rd_byte = {{(DATA_W-SEL_W){1'b0}}, select_reg};
    end else if (idx == IDX_DATA_WINDOW) begin
      rd_byte = window_reg;
    end else if (idx == IDX_UPDATE_CTRL) begin
      rd_byte = {{(DATA_W-1){1'b0}}, trigger_reg};
    end else if (idx == IDX_IRQ_EN_LOW) begin
      rd_byte = {{(DATA_W-FLAG_LOW_W){1'b0}}, enable_reg[FLAG_LOW_W-1:0]};
    end else if (idx == IDX_IRQ_EN_HIGH) begin
      rd_byte = {{(DATA_W-1){1'b0}}, enable_reg[CNT_LCV]};
    end else if (idx == IDX_FLAGS_LOW) begin
      rd_byte = {{(DATA_W-FLAG_LOW_W){1'b0}}, flags_reg[FLAG_LOW_W-1:0]};
    end else if (idx == IDX_FLAGS_HIGH) begin
      rd_byte = {{(DATA_W-1){1'b0}}, flags_reg[CNT_LCV]};
    end else if (idx == IDX_MONITOR_CFG) begin
      rd_byte = {{(DATA_W-CFG_W){1'b0}}, cfg_reg};
    end else begin
      rd_byte = BYTE_RST;
    end
  end

  // Data captured in the wait cycle, stands at the accepting edge
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      readdata_reg <= '0;
    end else if (req & waitreq_reg & AVS_READ_I) begin
      readdata_reg <= {{(BUS_W-DATA_W){1'b0}}, rd_byte};
    end
  end

  // Software-written control
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      select_reg  <= SELECT_RST;
      trigger_reg <= 1'b0;
      cfg_reg     <= CFG_RST;
    end else if (wr_en) begin
      if (idx == IDX_SELECT_PORT) begin
        select_reg <= AVS_WRITEDATA_I[SEL_W-1:0];
      end else if (idx == IDX_UPDATE_CTRL) begin
        trigger_reg <= AVS_WRITEDATA_I[UPD_MANUAL_BIT];
      end else if (idx == IDX_MONITOR_CFG) begin
        cfg_reg <= AVS_WRITEDATA_I[CFG_W-1:0];
      end
    end
  end

  // Next enables feed the interrupt so a mask write acts with no lag
  always_comb begin
    enable_next = enable_reg;
    if (wr_en & (idx == IDX_IRQ_EN_LOW)) begin
      enable_next[FLAG_LOW_W-1:0] = AVS_WRITEDATA_I[FLAG_LOW_W-1:0];
    end else if (wr_en & (idx == IDX_IRQ_EN_HIGH)) begin
      enable_next[CNT_LCV] = AVS_WRITEDATA_I[0];
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      enable_reg <= '0;
    end else begin
      enable_reg <= enable_next;
    end
  end

  // One-second tick runs free so auto reports keep a steady period
  assign tick_end = (tick_reg == TICK_W'(SECOND_CYCLES - 1));

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      tick_reg <= '0;
    end else if (tick_end) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_reg + TICK_W'(1);
    end
  end

  // Snapshot sources
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      trigger_prev_reg <= 1'b0;
    end else begin
      trigger_prev_reg <= trigger_reg;
    end
  end

  assign manual_rise = trigger_reg & ~trigger_prev_reg;
  assign snap        = manual_rise | (auto_en & tick_end);

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      window_reg <= BYTE_RST;
    end else if (snap) begin
      window_reg <= pick_byte(select_reg, cnt_reg);
    end
  end

  // Event steering by framing format
  always_comb begin
    inc           = '0;
    inc[CNT_LCV]  = b8zs_mode ? B8ZS_CV_EVENT_I : BPV_EVENT_I;
    inc[CNT_FER]  = (fmt == FMT_ESF) ? FAS_ERR_EVENT_I
                                     : FBIT_ERR_EVENT_I;
    inc[CNT_CRC]  = (fmt == FMT_ESF) & CRC6_ERR_EVENT_I;
    inc[CNT_DDS]  = (fmt == FMT_DM) & ~j1_mode & DDS_ERR_EVENT_I;
    inc[CNT_COFA] = ALIGN_CHANGE_EVENT_I;
    inc[CNT_OOF]  = FRAME_LOSS_EVENT_I;
    inc[CNT_PRGD] = PATTERN_ERR_EVENT_I;
  end

  // Counters; a copy reports the old value and restarts from this
  // cycle's event so nothing slips between rounds
  for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
    assign ovf[i] = inc[i] & ~snap & (cnt_reg[i] == CNT_MAX[i]);

    always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
        cnt_reg[i] <= '0;
      end else if (snap) begin
        cnt_reg[i] <= CNT_W'(inc[i]);
      end else if (inc[i] & (cnt_reg[i] != CNT_MAX[i])) begin
        cnt_reg[i] <= cnt_reg[i] + CNT_W'(1);
      end
    end
  end

  // Read clears only the bits that were returned; a new set wins
  always_comb begin
    flags_clr = '0;
    if (accept & AVS_READ_I & (idx == IDX_FLAGS_LOW)) begin
      flags_clr[FLAG_LOW_W-1:0] = readdata_reg[FLAG_LOW_W-1:0];
    end else if (accept & AVS_READ_I & (idx == IDX_FLAGS_HIGH)) begin
      flags_clr[CNT_LCV] = readdata_reg[0];
    end
    flags_next = (flags_reg & ~flags_clr) | ovf;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flags_next & enable_next);
    end
  end

  assign AVS_READDATA_O    = readdata_reg;
  assign AVS_WAITREQUEST_O = waitreq_reg;
  assign IRQ_O             = irq_reg;

  // Checks
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  a_overflow_sets_flag: assert property (
    inc[CNT_LCV] && !snap && cnt_reg[CNT_LCV] == CNT_MAX[CNT_LCV]
    |=> flags_reg[CNT_LCV] && cnt_reg[CNT_LCV] == CNT_MAX[CNT_LCV])
    else $error("Line code overflow did not set its flag");

  a_irq_gated: assert property (
    IRQ_O |-> (flags_reg & enable_reg) != '0)
    else $error("Interrupt raised without an enabled flag");

  a_flag_sticky: assert property (
    !(accept && AVS_READ_I)
    |=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
    else $error("Overflow flag dropped without a read");

  a_irq_or_flags: assert property (
    (flags_reg & enable_reg) != '0 |-> IRQ_O)
    else $error("Enabled flag set but interrupt low");

  a_auto_period: assert property (
    auto_en && tick_end && !trigger_reg |=> !tick_end [*8])
    else $error("Auto report tick period too short");

  a_auto_report: assert property (
    auto_en && tick_end
    |=> window_reg == $past(pick_byte(select_reg, cnt_reg)))
    else $error("Auto report did not load the window");

  a_manual_report: assert property (
    $rose(trigger_reg) |-> snap
    ##1 window_reg == $past(pick_byte(select_reg, cnt_reg)))
    else $error("Manual edge did not load the window");

  a_window_hold: assert property (
    !snap |=> $stable(window_reg))
    else $error("Data window changed without a snapshot");

  a_group_clear: assert property (
    snap |=> cnt_reg[CNT_PRGD] == CNT_W'($past(inc[CNT_PRGD]))
      && cnt_reg[CNT_FER] == CNT_W'($past(inc[CNT_FER])))
    else $error("Counters not restarted after copy");

  a_crc_esf_only: assert property (
    fmt != FMT_ESF && !snap |=> $stable(cnt_reg[CNT_CRC]))
    else $error("CRC counter moved outside ESF");

  a_dds_dm_only: assert property (
    (fmt != FMT_DM || j1_mode) && !snap |=> $stable(cnt_reg[CNT_DDS]))
    else $error("DDS counter moved outside T1 DM");

  a_align_count: assert property (
    ALIGN_CHANGE_EVENT_I && !snap && cnt_reg[CNT_COFA] != CNT_MAX[CNT_COFA]
    |=> cnt_reg[CNT_COFA] == $past(cnt_reg[CNT_COFA]) + CNT_W'(1))
    else $error("Alignment change not counted");

  a_fer_source: assert property (
    fmt == FMT_ESF && !FAS_ERR_EVENT_I && !snap
    |=> $stable(cnt_reg[CNT_FER]))
    else $error("Framing counter took wrong source in ESF");

  a_lcv_source: assert property (
    b8zs_mode && !B8ZS_CV_EVENT_I && !snap |=> $stable(cnt_reg[CNT_LCV]))
    else $error("Line code counter took wrong source");

  a_one_wait: assert property (
    req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
    else $error("Bus answer not after one wait state");

  c_manual_snap: cover property (manual_rise ##1 window_reg != BYTE_RST);
  c_auto_snap:   cover property (auto_en && tick_end);
  c_overflow:    cover property (|ovf ##1 IRQ_O);
  c_snap_event:  cover property (snap && |inc);
  c_flag_clear:  cover property (flags_clr != '0);

  // Every counter, not only line code, must flag its overflow
  for (genvar j = 0; j < NUM_CNT; j++) begin : g_ovf_chk
    a_cnt_ovf_flag: assert property (
      inc[j] && !snap && cnt_reg[j] == CNT_MAX[j] |=> flags_reg[j])
      else $error("Counter overflow did not set its flag");
  end

endmodule

/* File: inc/perf_monitor_pkg.sv */
// Purpose: Shared constants and types of the performance-monitor counters
// Assumes: 50 MHz system clock, one monitored link
// Notes:   Register indexes are word indexes; byte address is index times 4
package perf_monitor_pkg;

  // Clock and report timing
  localparam int     CLK_PERIOD_NS     = 20;
  localparam longint ONE_SECOND_NS     = 1000000000;
  localparam int     ONE_SECOND_CYCLES = int'(ONE_SECOND_NS / CLK_PERIOD_NS);
  localparam int     TICK_W            = 26;

  // Bus geometry
  localparam int ADDR_W    = 10;
  localparam int BUS_W     = 32;
  localparam int BE_W      = 4;
  localparam int IDX_LSB   = 2;
  localparam int IDX_W     = 8;
  localparam int DATA_W    = 8;
  localparam int SEL_W     = 4;

  // Register word indexes
  localparam logic [IDX_W-1:0] IDX_SELECT_PORT  = 8'h0E;
  localparam logic [IDX_W-1:0] IDX_DATA_WINDOW  = 8'h0F;
  localparam logic [IDX_W-1:0] IDX_UPDATE_CTRL  = 8'hC2;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN_LOW   = 8'hC3;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN_HIGH  = 8'hC4;
  localparam logic [IDX_W-1:0] IDX_FLAGS_LOW    = 8'hC5;
  localparam logic [IDX_W-1:0] IDX_FLAGS_HIGH   = 8'hC6;
  localparam logic [IDX_W-1:0] IDX_MONITOR_CFG  = 8'hC7;

  // Field positions
  localparam int UPD_MANUAL_BIT = 0;
  localparam int CFG_FMT_LSB    = 0;
  localparam int CFG_B8ZS_BIT   = 2;
  localparam int CFG_J1_BIT     = 3;
  localparam int CFG_AUTO_BIT   = 4;
  localparam int CFG_W          = 5;
  localparam int FLAG_LOW_W     = 6;

  // Reset values
  localparam logic [SEL_W-1:0]  SELECT_RST = 4'h0;
  localparam logic [DATA_W-1:0] BYTE_RST   = 8'h00;
  localparam logic [CFG_W-1:0]  CFG_RST    = 5'h00;

  // Counter bank: id order matches flag bit order
  localparam int NUM_CNT  = 7;
  localparam int CNT_W    = 16;
  localparam int CNT_CRC  = 0;
  localparam int CNT_FER  = 1;
  localparam int CNT_COFA = 2;
  localparam int CNT_OOF  = 3;
  localparam int CNT_PRGD = 4;
  localparam int CNT_DDS  = 5;
  localparam int CNT_LCV  = 6;
  localparam logic [CNT_W-1:0] CNT_MAX [NUM_CNT] = '{
    16'h03FF, 16'h0FFF, 16'h0007, 16'h001F, 16'hFFFF, 16'h03FF, 16'hFFFF};

  // Indirect indexes
  localparam logic [SEL_W-1:0] SEL_CRC_LO  = 4'h0;
  localparam logic [SEL_W-1:0] SEL_CRC_HI  = 4'h1;
  localparam logic [SEL_W-1:0] SEL_FER_LO  = 4'h2;
  localparam logic [SEL_W-1:0] SEL_FER_HI  = 4'h3;
  localparam logic [SEL_W-1:0] SEL_COFA    = 4'h4;
  localparam logic [SEL_W-1:0] SEL_OOF     = 4'h5;
  localparam logic [SEL_W-1:0] SEL_PRGD_LO = 4'h6;
  localparam logic [SEL_W-1:0] SEL_PRGD_HI = 4'h7;
  localparam logic [SEL_W-1:0] SEL_LCV_LO  = 4'h8;
  localparam logic [SEL_W-1:0] SEL_LCV_HI  = 4'h9;
  localparam logic [SEL_W-1:0] SEL_DDS_LO  = 4'hA;
  localparam logic [SEL_W-1:0] SEL_DDS_HI  = 4'hB;

  // Framing formats, Gray ordered
  typedef enum logic [1:0] {
    FMT_SF  = 2'h0,
    FMT_ESF = 2'h1,
    FMT_DM  = 2'h3,
    FMT_LCF = 2'h2
  } frame_format_type;

endpackage

/* File: testbench/avalon_host_model.sv */
// Purpose: Avalon-MM host model for the monitor register port
// Assumes: Slave answers by lowering waitrequest, sampled at rising edges
// Notes:   Waits without limit; only the bench timeout ends a hang
`timescale 1ns/10ps
module avalon_host_model (
  // Clock and answer
  input  wire logic                                clk_i,
  input  wire logic                                waitrequest_i,
  // Request
  output logic      [perf_monitor_pkg::ADDR_W-1:0] address_o,
  output logic                                     read_o,
  output logic                                     write_o,
  output logic      [perf_monitor_pkg::BUS_W-1:0]  writedata_o,
  output logic      [perf_monitor_pkg::BE_W-1:0]   byteenable_o
);
  import perf_monitor_pkg::*;
  initial begin
    address_o    = '0;
    read_o       = 1'b0;
    write_o      = 1'b0;
    writedata_o  = '0;
    byteenable_o = '0;
  end
  // Held whole until waitrequest seen low; counters only via the window
  task automatic access(input logic [7:0] idx, input logic is_wr,
                        input logic [7:0] data, input logic [3:0] be);
    @(posedge clk_i);
    address_o    <= {idx, 2'b00};
    read_o       <= ~is_wr;
    write_o      <= is_wr;
    writedata_o  <= {24'h000000, data};
    byteenable_o <= be;
    @(posedge clk_i);
    while (waitrequest_i !== 1'b0) @(posedge clk_i);
    read_o  <= 1'b0;
    write_o <= 1'b0;
  endtask
endmodule

/* File: testbench/perf_monitor_counters_test.sv */
// Purpose: Self-checking bench of the performance-monitor counters
// Assumes: Short one-second period set through SECOND_CYCLES
// Notes:   Reads queue their expectation; a monitor compares on accept
`timescale 1ns/10ps
module perf_monitor_counters_test;
  import perf_monitor_pkg::*;
  localparam int unsigned SEC     = 64;
  localparam int          TIMEOUT = 20000;
  logic                 clk_sys = 1'b0;
  logic                 rst     = 1'b1;
  logic [ADDR_W-1:0]    address;
  logic                 read, write, waitreq, irq;
  logic [BUS_W-1:0]     writedata, readdata;
  logic [BE_W-1:0]      byteenable;
  logic [8:0]           ev      = '0;
  logic [BUS_W-1:0]     exp_q [$];
  int                   err_count = 0;
  int                   n_checks  = 0;
  int                   cycles    = 0;
  int                   seed      = 7;
  int                   cnt [9];

  initial forever #10 clk_sys = ~clk_sys;

  perf_monitor_counters #(.SECOND_CYCLES(SEC)) perf_monitor_counters_inst (
    .CLK_SYS_I(clk_sys), .RST_I(rst), .AVS_ADDRESS_I(address),
    .AVS_READ_I(read), .AVS_WRITE_I(write), .AVS_WRITEDATA_I(writedata),
    .AVS_BYTEENABLE_I(byteenable), .AVS_READDATA_O(readdata),
    .AVS_WAITREQUEST_O(waitreq), .BPV_EVENT_I(ev[0]),
    .B8ZS_CV_EVENT_I(ev[1]), .FBIT_ERR_EVENT_I(ev[2]),
    .FAS_ERR_EVENT_I(ev[3]), .CRC6_ERR_EVENT_I(ev[4]),
    .DDS_ERR_EVENT_I(ev[5]), .ALIGN_CHANGE_EVENT_I(ev[6]),
    .FRAME_LOSS_EVENT_I(ev[7]), .PATTERN_ERR_EVENT_I(ev[8]), .IRQ_O(irq));

  avalon_host_model avalon_host_model_inst (
    .clk_i(clk_sys), .waitrequest_i(waitreq), .address_o(address),
    .read_o(read), .write_o(write), .writedata_o(writedata),
    .byteenable_o(byteenable));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    avalon_host_model_inst.access(idx, 1'b1, d, 4'hF);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    avalon_host_model_inst.access(idx, 1'b0, 8'h00, 4'hF);
  endtask

  // Write 0 then 1: a held 1 would not retrigger
  task automatic snap(input logic [3:0] sel);
    wr(IDX_SELECT_PORT, {4'h0, sel});
    wr(IDX_UPDATE_CTRL, 8'h00);
    wr(IDX_UPDATE_CTRL, 8'h01);
  endtask

  // All event lines pulse together, line k for cnt[k] cycles
  task automatic burst();
    int n;
    n = 0;
    foreach (cnt[k]) if (cnt[k] > n) n = cnt[k];
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      for (int k = 0; k < 9; k++) ev[k] <= (i < cnt[k]);
    end
    @(posedge clk_sys);
    ev <= '0;
  endtask

  function automatic logic [7:0] expect_lo(input logic [3:0] sel,
    input logic [1:0] fmt, input logic b8, input logic j1);
    case (sel)
      SEL_CRC_LO:  return 8'((fmt == FMT_ESF) ? cnt[4] : 0);
      SEL_FER_LO:  return 8'((fmt == FMT_ESF) ? cnt[3] : cnt[2]);
      SEL_COFA:    return 8'(cnt[6]);
      SEL_OOF:     return 8'(cnt[7]);
      SEL_PRGD_LO: return 8'(cnt[8]);
      SEL_LCV_LO:  return 8'(b8 ? cnt[1] : cnt[0]);
      SEL_DDS_LO:  return 8'((fmt == FMT_DM && !j1) ? cnt[5] : 0);
      default:     return 8'h00;
    endcase
  endfunction

  always @(posedge clk_sys) begin
    if (!rst && read === 1'b1 && waitreq === 1'b0) begin
      if (exp_q.size() == 0) begin
        err_count++;
      end else begin
        check(readdata, exp_q.pop_front());
      end
    end
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    logic [7:0] v;
    logic [7:0] regs [9] = '{IDX_SELECT_PORT, IDX_DATA_WINDOW,
      IDX_UPDATE_CTRL, IDX_IRQ_EN_LOW, IDX_IRQ_EN_HIGH, IDX_FLAGS_LOW,
      IDX_FLAGS_HIGH, IDX_MONITOR_CFG, 8'h10};
    logic [7:0] rw_idx [4] = '{IDX_SELECT_PORT, IDX_IRQ_EN_LOW,
      IDX_IRQ_EN_HIGH, IDX_MONITOR_CFG};
    logic [7:0] rw_mask [4] = '{8'h0F, 8'h3F, 8'h01, 8'h1F};
    logic [3:0] sels [7] = '{SEL_CRC_LO, SEL_FER_LO, SEL_COFA, SEL_OOF,
      SEL_PRGD_LO, SEL_LCV_LO, SEL_DDS_LO};
    logic [4:0] cfgs [5] = '{5'h00, 5'h05, 5'h03, 5'h06, 5'h0F};
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    foreach (regs[i]) rd(regs[i], 8'h00);
    @(negedge clk_sys);
    check(32'(irq), 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      wr(rw_idx[i], v);
      rd(rw_idx[i], v & rw_mask[i]);
    end
    // Refused writes: no byte enable, read-only flags, unmapped index
    wr(IDX_SELECT_PORT, 8'h05);
    avalon_host_model_inst.access(IDX_SELECT_PORT, 1'b1, 8'h0A, 4'h0);
    rd(IDX_SELECT_PORT, 8'h05);
    wr(IDX_FLAGS_LOW, 8'hFF);
    rd(IDX_FLAGS_LOW, 8'h00);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    wr(IDX_IRQ_EN_LOW, 8'h00);
    wr(IDX_IRQ_EN_HIGH, 8'h00);
    // Every format steers events; each counter needs its own snapshot
    foreach (cfgs[c]) begin
      wr(IDX_MONITOR_CFG, {3'h0, cfgs[c]});
      snap(SEL_CRC_LO);
      foreach (sels[s]) begin
        foreach (cnt[k]) cnt[k] = $unsigned($random(seed)) % 7 + 1;
        burst();
        snap(sels[s]);
        rd(IDX_DATA_WINDOW, expect_lo(sels[s], cfgs[c][1:0], cfgs[c][2],
          cfgs[c][3]));
      end
    end
    // Overflow of alignment and framing counters, alignment interrupt masked then enabled
    wr(IDX_MONITOR_CFG, 8'h00);
    cnt = '{0, 0, 4097, 0, 0, 0, 8, 0, 0};
    burst();
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check(32'(irq), 32'h0);
    wr(IDX_IRQ_EN_LOW, 8'h04);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check(32'(irq), 32'h1);
    rd(IDX_FLAGS_LOW, 8'h06);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check(32'(irq), 32'h0);
    rd(IDX_FLAGS_LOW, 8'h00);
    snap(SEL_FER_HI);
    rd(IDX_DATA_WINDOW, 8'h0F);
    cnt = '{0, 0, 0, 0, 0, 0, 0, 0, 300};
    burst();
    snap(SEL_PRGD_HI);
    rd(IDX_DATA_WINDOW, 8'h01);
    // Auto report with an event every cycle: each round holds SEC events
    snap(SEL_PRGD_LO);
    wr(IDX_MONITOR_CFG, 8'h10);
    ev[8] <= 1'b1;
    repeat (4 * SEC) @(posedge clk_sys);
    rd(IDX_DATA_WINDOW, 8'(SEC));
    ev <= '0;
    wr(IDX_MONITOR_CFG, 8'h00);
    repeat (2) @(posedge clk_sys);
    check(32'(exp_q.size()), 32'h0);
    conclude();
  end
endmodule
